// ### design/mds_consts.svh
// register map, field positions, reset values and timing figures of the supervisor
`ifndef MDS_CONSTS_SVH
`define MDS_CONSTS_SVH

`define MDS_ADDR_SPD_LO 8'h00
`define MDS_ADDR_SPD_HI 8'h01
`define MDS_ADDR_CTRL 8'h02
`define MDS_ADDR_STATUS 8'h10
`define MDS_ADDR_FCODE 8'h1e

`define MDS_CTRL_VSEL 0
`define MDS_CTRL_LPDIS 1
`define MDS_CTRL_SRC_LO 2
`define MDS_CTRL_SRC_HI 3
`define MDS_SPD_HI_BIT 0

`define MDS_ST_OT 7
`define MDS_ST_LP 6
`define MDS_ST_OC 5
`define MDS_ST_LOCK 4

`define MDS_SPD_RST 9'h000
`define MDS_RDATA_RST 8'h00
`define MDS_FCODE_RST 3'h0

`define MDS_CLK_HZ 10000000
`define MDS_LOCK_OFF_MS 5000
`define MDS_LOCK_ENTER_MS 300
`define MDS_LP_ENTER_MS 58
`define MDS_LP_EXIT_MS 1

`define MDS_PWM_WIN_LAST 9'h1fe
`define MDS_ANA_ENTER_LVL 9'h010
`define MDS_ANA_EXIT_LVL 9'h020

`define MDS_ANG_Q 7'h18
`define MDS_ANG_H 7'h30
`define MDS_ANG_3Q 7'h48
`define MDS_ANG_FULL 7'h60
`define MDS_ANG_THIRD 7'h20

`endif

// ### design/mds_modulator.sv
// three-phase flat-bottom sine modulator scaled by the peak duty
`timescale 1ns/100ps
`include "mds_consts.svh"

module mds_modulator (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cen_i,
  input wire logic en_i,
  input wire logic [6:0] angle_i,
  input wire logic [8:0] peak_i,
  output logic [8:0] duty_u_o,
  output logic [8:0] duty_v_o,
  output logic [8:0] duty_w_o
);
  import mds_pkg::*;

  // quarter wave, amplitude chosen so that the line-to-line peak reaches 255
  localparam logic [7:0] SIN_Q [25] = '{
    8'h00, 8'h0a, 8'h13, 8'h1d, 8'h26, 8'h2f, 8'h38, 8'h41, 8'h4a, 8'h52,
    8'h59, 8'h61, 8'h68, 8'h6f, 8'h75, 8'h7a, 8'h7f, 8'h84, 8'h88, 8'h8b,
    8'h8e, 8'h90, 8'h92, 8'h93, 8'h93};

  function automatic logic signed [8:0] sin_of(input logic [6:0] a);
    logic [6:0] i;
    logic neg;
    i = a;
    neg = 1'b0;
    if (a <= `MDS_ANG_Q) begin
      i = a;
    end else if (a <= `MDS_ANG_H) begin
      i = `MDS_ANG_H - a;
    end else if (a <= `MDS_ANG_3Q) begin
      i = a - `MDS_ANG_H;
      neg = 1'b1;
    end else begin
      i = `MDS_ANG_FULL - a;
      neg = 1'b1;
    end
    sin_of = neg ? -$signed({1'b0, SIN_Q[i[4:0]]}) : $signed({1'b0, SIN_Q[i[4:0]]});
  endfunction

  mds_mod_t st;
  mds_mod_t next_st;
  logic [6:0] base;
  logic signed [8:0] s [3];
  logic signed [8:0] mn;
  logic [8:0] d [3];

  // out-of-range angles fold to zero rather than index past the table
  assign base = (angle_i >= `MDS_ANG_FULL) ? 7'h00 : angle_i;

  // ************************************************************
  // per-phase sine, 120 degrees apart
  // ************************************************************
  genvar p;
  generate
    for (p = 0; p < 3; p++) begin : g_ph
      logic [7:0] sum;
      logic [6:0] ang;
      logic signed [8:0] diff;
      logic [17:0] prod;
      assign sum = {1'b0, base} + 8'(p) * {1'b0, `MDS_ANG_THIRD};
      assign ang = (sum >= {1'b0, `MDS_ANG_FULL}) ? 7'(sum - {1'b0, `MDS_ANG_FULL}) : sum[6:0];
      assign s[p] = sin_of(ang);
      // the lowest phase sits at ground; the rest carry the third harmonic
      assign diff = s[p] - mn;
      // full scale of the difference maps onto the peak duty
      assign prod = diff * peak_i;
      assign d[p] = prod[16:8];
    end
  endgenerate

  always_comb begin
    mn = s[0];
    if (s[1] < mn) begin
      mn = s[1];
    end
    if (s[2] < mn) begin
      mn = s[2];
    end
  end

  always_comb begin
    next_st = st;
    next_st.du = en_i ? d[0] : 9'h000;
    next_st.dv = en_i ? d[1] : 9'h000;
    next_st.dw = en_i ? d[2] : 9'h000;
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else if (cen_i) begin
      st <= next_st;
    end
  end

  assign duty_u_o = st.du;
  assign duty_v_o = st.dv;
  assign duty_w_o = st.dw;

  default clocking cb @(posedge mclk_i iff cen_i); endclocking
  default disable iff (!arst_n_i);

  property p_flat_bottom;
    en_i |=> (duty_u_o == 9'h000) || (duty_v_o == 9'h000) || (duty_w_o == 9'h000);
  endproperty
  a_flat_bottom: assert property (p_flat_bottom) else $error("no phase held at ground");

  property p_zero_peak;
    (peak_i == 9'h000) |=> (duty_u_o | duty_v_o | duty_w_o) == 9'h000;
  endproperty
  a_zero_peak: assert property (p_zero_peak) else $error("duty present at zero peak");
endmodule

// ### design/mds_pkg.sv
// types shared by the motor drive supervisor and its modulator
package mds_pkg;

  typedef enum logic [1:0] {
    MDS_SRC_PWM = 2'b00,
    MDS_SRC_ANA = 2'b01,
    MDS_SRC_SER = 2'b10
  } mds_src_t;

  typedef enum logic [1:0] {
    MDS_LK_RUN = 2'b00,
    MDS_LK_OFF = 2'b01,
    MDS_LK_RETRY = 2'b10
  } mds_lock_t;

  typedef struct packed {
    logic [8:0] spd;
    logic vsel;
    logic lpdis;
    logic [1:0] src;
    logic [7:0] rdata;
    logic ot;
    logic uv;
    logic oc;
    mds_lock_t lk;
    logic [31:0] lk_cnt;
    logic [2:0] fcode;
    logic lp;
    logic [31:0] lp_cnt;
    logic [8:0] win;
    logic [8:0] hi;
    logic [8:0] pwm_duty;
    logic hs_on;
    logic [8:0] peak;
  } mds_sup_t;

  typedef struct packed {
    logic [8:0] du;
    logic [8:0] dv;
    logic [8:0] dw;
  } mds_mod_t;

endpackage

// ### design/mds_supervisor.sv
// motor drive supervisor: protection, speed source, low power and regulator control
//
// Notes on behaviour
// - regulator target is 5 V with select bit 0, 3.3 V with bit 1.
// - high-side switch turns on when output drops by hysteresis, off at target.
// - over-temperature stops driving until cooled below hysteresis; status bit 7 shows it.
// - undervoltage locks out at falling level, releases only at the higher rising level.
// - overcurrent puts all phases high impedance while present; status bit 5 set.
// - blocked rotor stops drive, waits release time, retries, repeating while blocked.
// - lock sets status bit 4 and records the cause in the fault code register.
// - speed command comes from pin PWM, pin analog level, or 9-bit serial field.
// - peak duty follows the command but external limiters may only reduce it.
// - phase voltages carry third harmonic; one phase grounded, two modulated.
// - peak duty 100 percent gives supply amplitude, 50 percent half supply.
// - sleep or standby stops driving the motor outputs.
// - sleep variant disables regulator and serial port and resets speed and control registers; fault code is kept.
// - standby variant keeps regulator, registers and serial port alive.
// - low-power disable blocks entry but does not force an exit.
// - status bit 6 is set throughout sleep or standby.
// - serial speed zero for entry time enters low power; nonzero leaves standby.
// - serial command cannot end sleep; only speed pin activity does.
`timescale 1ns/100ps
`include "mds_consts.svh"

module mds_supervisor #(
  parameter bit SLEEP_VARIANT = 1'b0,
  parameter int unsigned LOCK_OFF_CYC = `MDS_LOCK_OFF_MS * (`MDS_CLK_HZ / 1000),
  parameter int unsigned LOCK_ENTER_CYC = `MDS_LOCK_ENTER_MS * (`MDS_CLK_HZ / 1000),
  parameter int unsigned LP_ENTER_CYC = `MDS_LP_ENTER_MS * (`MDS_CLK_HZ / 1000),
  parameter int unsigned LP_EXIT_CYC = `MDS_LP_EXIT_MS * (`MDS_CLK_HZ / 1000)
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cen_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  output logic [7:0] reg_rdata_o,
  input wire logic speed_pin_i,
  input wire logic [8:0] speed_level_i,
  input wire logic temp_over_i,
  input wire logic temp_cool_i,
  input wire logic vcc_fall_i,
  input wire logic vcc_rise_i,
  input wire logic oc_i,
  input wire logic lock_i,
  input wire logic [2:0] lock_cause_i,
  input wire logic [8:0] duty_limit_i,
  input wire logic [6:0] elec_angle_i,
  input wire logic vreg_low_i,
  input wire logic vreg_ok_i,
  output logic vreg_target_sel_o,
  output logic vreg_hs_on_o,
  output logic vreg_en_o,
  output logic serial_en_o,
  output logic uvlo_o,
  output logic [8:0] output_peak_duty_o,
  output logic [8:0] duty_u_o,
  output logic [8:0] duty_v_o,
  output logic [8:0] duty_w_o,
  output logic [2:0] phase_oe_o
);
  import mds_pkg::*;

  // ************************************************************
  // elaboration checks
  // ************************************************************
  if (LOCK_OFF_CYC < 1 || LOCK_ENTER_CYC < 1) begin : g_chk_lock
    $error("lock timing counts must be at least one cycle");
  end
  if (LP_ENTER_CYC < 1 || LP_EXIT_CYC < 1) begin : g_chk_lp
    $error("low-power dwell counts must be at least one cycle");
  end

  localparam logic [31:0] LOCK_OFF_LAST = 32'(LOCK_OFF_CYC - 1);
  localparam logic [31:0] LOCK_ENTER_LAST = 32'(LOCK_ENTER_CYC - 1);
  localparam logic [31:0] LP_ENTER_LAST = 32'(LP_ENTER_CYC - 1);
  localparam logic [31:0] LP_EXIT_LAST = 32'(LP_EXIT_CYC - 1);

  mds_sup_t st;
  mds_sup_t next_st;
  logic drive;
  logic ser_on;
  logic wr_ok;
  logic enter_cond;
  logic exit_cond;
  logic [8:0] cmd;
  logic [7:0] status;
  mds_src_t src;

  assign src = mds_src_t'(st.src);
  // serial port is dead while the sleep variant sleeps
  assign ser_on = !(SLEEP_VARIANT && st.lp);
  assign wr_ok = reg_wr_i && ser_on;
  // any protection or low power takes the phases off
  assign drive = !st.ot && !st.uv && !st.oc && (st.lk != MDS_LK_OFF) && !st.lp;

  // ************************************************************
  // status view
  // ************************************************************
  always_comb begin
    status = 8'h00;
    status[`MDS_ST_OT] = st.ot;
    status[`MDS_ST_LP] = st.lp;
    status[`MDS_ST_OC] = st.oc;
    status[`MDS_ST_LOCK] = (st.lk != MDS_LK_RUN);
  end

  // ************************************************************
  // speed source selection
  // ************************************************************
  always_comb begin
    unique case (src)
      MDS_SRC_PWM: cmd = st.pwm_duty;
      MDS_SRC_ANA: cmd = speed_level_i;
      MDS_SRC_SER: cmd = st.spd;
      default: cmd = `MDS_SPD_RST;
    endcase
  end

  // ************************************************************
  // low-power entry and exit conditions
  // ************************************************************
  always_comb begin
    unique case (src)
      MDS_SRC_ANA: enter_cond = speed_level_i < `MDS_ANA_ENTER_LVL;
      MDS_SRC_SER: enter_cond = (st.spd == `MDS_SPD_RST);
      default: enter_cond = !speed_pin_i;
    endcase
    if (SLEEP_VARIANT) begin
      // registers were wiped on entry, so only the pin can wake the part
      exit_cond = (src == MDS_SRC_ANA) ? (speed_level_i > `MDS_ANA_EXIT_LVL) : speed_pin_i;
    end else begin
      unique case (src)
        MDS_SRC_ANA: exit_cond = speed_level_i > `MDS_ANA_EXIT_LVL;
        MDS_SRC_SER: exit_cond = (st.spd != `MDS_SPD_RST);
        default: exit_cond = speed_pin_i;
      endcase
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    next_st = st;

    // register writes, only while the serial port runs
    if (wr_ok) begin
      unique case (reg_addr_i)
        `MDS_ADDR_SPD_LO: next_st.spd[7:0] = reg_wdata_i;
        `MDS_ADDR_SPD_HI: next_st.spd[8] = reg_wdata_i[`MDS_SPD_HI_BIT];
        `MDS_ADDR_CTRL: begin
          next_st.vsel = reg_wdata_i[`MDS_CTRL_VSEL];
          next_st.lpdis = reg_wdata_i[`MDS_CTRL_LPDIS];
          next_st.src = reg_wdata_i[`MDS_CTRL_SRC_HI:`MDS_CTRL_SRC_LO];
        end
        default: ;
      endcase
    end

    // reads are registered; unmapped addresses answer zero
    if (reg_rd_i && ser_on) begin
      unique case (reg_addr_i)
        `MDS_ADDR_SPD_LO: next_st.rdata = st.spd[7:0];
        `MDS_ADDR_SPD_HI: next_st.rdata = {7'h00, st.spd[8]};
        `MDS_ADDR_CTRL: next_st.rdata = {4'h0, st.src, st.lpdis, st.vsel};
        `MDS_ADDR_STATUS: next_st.rdata = status;
        `MDS_ADDR_FCODE: next_st.rdata = {5'h00, st.fcode};
        default: next_st.rdata = `MDS_RDATA_RST;
      endcase
    end

    // flags that hardware sets win over their clearing event
    if (temp_over_i) begin
      next_st.ot = 1'b1;
    end else if (temp_cool_i) begin
      next_st.ot = 1'b0;
    end
    if (vcc_fall_i) begin
      next_st.uv = 1'b1;
    end else if (vcc_rise_i) begin
      next_st.uv = 1'b0;
    end
    next_st.oc = oc_i;

    // pwm duty meter: fraction of high samples over one window
    if (st.win == `MDS_PWM_WIN_LAST) begin
      next_st.win = 9'h000;
      next_st.hi = 9'h000;
      next_st.pwm_duty = st.hi + {8'h00, speed_pin_i};
    end else begin
      next_st.win = st.win + 9'h001;
      next_st.hi = st.hi + {8'h00, speed_pin_i};
    end

    // limiters can only pull the peak below the command
    next_st.peak = (cmd > duty_limit_i) ? duty_limit_i : cmd;

    // ************************************************************
    // lock protection cycle
    // ************************************************************
    unique case (st.lk)
      MDS_LK_RUN: begin
        if (lock_i && drive) begin
          next_st.lk = MDS_LK_OFF;
          next_st.lk_cnt = 32'h0;
          next_st.fcode = lock_cause_i;
        end
      end
      MDS_LK_OFF: begin
        if (st.lk_cnt == LOCK_OFF_LAST) begin
          next_st.lk = MDS_LK_RETRY;
          next_st.lk_cnt = 32'h0;
        end else begin
          next_st.lk_cnt = st.lk_cnt + 32'h1;
        end
      end
      MDS_LK_RETRY: begin
        if (lock_i) begin
          next_st.lk = MDS_LK_OFF;
          next_st.lk_cnt = 32'h0;
          next_st.fcode = lock_cause_i;
        end else if (st.lk_cnt == LOCK_ENTER_LAST) begin
          next_st.lk = MDS_LK_RUN;
          next_st.lk_cnt = 32'h0;
        end else begin
          next_st.lk_cnt = st.lk_cnt + 32'h1;
        end
      end
      default: begin
        next_st.lk = MDS_LK_RUN;
        next_st.lk_cnt = 32'h0;
      end
    endcase

    // ************************************************************
    // sleep or standby dwell
    // ************************************************************
    if (!st.lp) begin
      // the disable bit only blocks entry
      if (enter_cond && !st.lpdis) begin
        if (st.lp_cnt == LP_ENTER_LAST) begin
          next_st.lp = 1'b1;
          next_st.lp_cnt = 32'h0;
          if (SLEEP_VARIANT) begin
            // nothing here is nonvolatile, so every setting falls back
            next_st.spd = `MDS_SPD_RST;
            next_st.vsel = 1'b0;
            next_st.lpdis = 1'b0;
            next_st.src = MDS_SRC_PWM;
          end
        end else begin
          next_st.lp_cnt = st.lp_cnt + 32'h1;
        end
      end else begin
        next_st.lp_cnt = 32'h0;
      end
    end else begin
      if (exit_cond) begin
        if (st.lp_cnt == LP_EXIT_LAST) begin
          next_st.lp = 1'b0;
          next_st.lp_cnt = 32'h0;
        end else begin
          next_st.lp_cnt = st.lp_cnt + 32'h1;
        end
      end else begin
        next_st.lp_cnt = 32'h0;
      end
    end

    // ************************************************************
    // hysteretic step-down control
    // ************************************************************
    if (SLEEP_VARIANT && st.lp) begin
      next_st.hs_on = 1'b0;
    end else if (vreg_low_i) begin
      next_st.hs_on = 1'b1;
    end else if (vreg_ok_i) begin
      next_st.hs_on = 1'b0;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st <= '0;
    end else if (cen_i) begin
      st <= next_st;
    end
  end

  // ************************************************************
  // modulator
  // ************************************************************
  mds_modulator u_mod (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cen_i(cen_i),
    .en_i(drive),
    .angle_i(elec_angle_i),
    .peak_i(st.peak),
    .duty_u_o(duty_u_o),
    .duty_v_o(duty_v_o),
    .duty_w_o(duty_w_o)
  );

  assign reg_rdata_o = st.rdata;
  assign vreg_target_sel_o = st.vsel;
  assign vreg_hs_on_o = st.hs_on;
  assign vreg_en_o = ser_on;
  assign serial_en_o = ser_on;
  assign uvlo_o = st.uv;
  assign output_peak_duty_o = st.peak;
  assign phase_oe_o = {3{drive}};

  // ************************************************************
  // assertions
  // ************************************************************
  default clocking cb @(posedge mclk_i iff cen_i); endclocking
  default disable iff (!arst_n_i);

  property p_vsel;
    wr_ok && reg_addr_i == `MDS_ADDR_CTRL |=>
      vreg_target_sel_o == $past(reg_wdata_i[`MDS_CTRL_VSEL]);
  endproperty
  a_vsel: assert property (p_vsel) else $error("regulator select not taken");

  property p_hs;
    vreg_low_i && vreg_en_o |=> vreg_hs_on_o;
  endproperty
  a_hs: assert property (p_hs) else $error("high side not on after droop");

  property p_ot;
    temp_over_i |=> status[`MDS_ST_OT] && phase_oe_o == 3'h0;
  endproperty
  a_ot: assert property (p_ot) else $error("thermal shutdown not applied");

  property p_uv;
    vcc_fall_i ##1 !vcc_rise_i |=> uvlo_o && phase_oe_o == 3'h0;
  endproperty
  a_uv: assert property (p_uv) else $error("undervoltage lockout lost");

  property p_oc;
    oc_i |=> phase_oe_o == 3'h0 && status[`MDS_ST_OC];
  endproperty
  a_oc: assert property (p_oc) else $error("overcurrent did not float the phases");

  property p_lock;
    st.lk == MDS_LK_RUN && lock_i && drive |=> phase_oe_o == 3'h0 && status[`MDS_ST_LOCK]
      && st.fcode == $past(lock_cause_i);
  endproperty
  a_lock: assert property (p_lock) else $error("lock not handled");

  property p_lp;
    st.lp |-> phase_oe_o == 3'h0 && status[`MDS_ST_LP];
  endproperty
  a_lp: assert property (p_lp) else $error("driving in low power");

  property p_sleep;
    $rose(st.lp) && SLEEP_VARIANT |-> !vreg_en_o && !serial_en_o && st.spd == `MDS_SPD_RST;
  endproperty
  a_sleep: assert property (p_sleep) else $error("sleep left something alive");

  property p_stdby;
    !SLEEP_VARIANT |-> serial_en_o && vreg_en_o;
  endproperty
  a_stdby: assert property (p_stdby) else $error("standby shut the port");

  property p_lpdis;
    !st.lp && st.lpdis |=> !st.lp;
  endproperty
  a_lpdis: assert property (p_lpdis) else $error("entered low power while disabled");

  property p_peak;
    output_peak_duty_o <= $past(duty_limit_i) || $past(cen_i) == 1'b0;
  endproperty
  a_peak: assert property (p_peak) else $error("peak duty above limit");
endmodule

// ### verif/mds_motor_model.sv
// behavioural motor that reports a blocked rotor while its phases are driven
`timescale 1ns/100ps

module mds_motor_model #(
  parameter logic [2:0] CAUSE = 3'h5
) (
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic blocked_i,
  input wire logic [2:0] phase_oe_i,
  output logic lock_o,
  output logic [2:0] lock_cause_o
);
  // ****************
  // lock sensing
  // ****************
  // a stopped rotor only shows once the drivers push current, so no lock while off
  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      lock_o <= 1'b0;
    end else begin
      lock_o <= blocked_i && (phase_oe_i != 3'h0);
    end
  end
  // cause is inverted outside a lock so a stale capture cannot pass
  assign lock_cause_o = lock_o ? CAUSE : ~CAUSE;
endmodule

// ### verif/mds_supervisor_tb.sv
// self-checking bench for the motor drive supervisor
`timescale 1ns/100ps

module mds_supervisor_tb;
  import mds_pkg::*;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00;
  logic [7:0] reg_wdata_i = 8'h00;
  logic reg_wr_i = 1'b0, reg_rd_i = 1'b0, speed_pin_i = 1'b1, blocked = 1'b0;
  logic temp_over_i = 1'b0, temp_cool_i = 1'b0, vcc_fall_i = 1'b0, vcc_rise_i = 1'b0;
  logic oc_i = 1'b0, vreg_low_i = 1'b0, vreg_ok_i = 1'b0, cen_i = 1'b1, lock_i;
  logic [8:0] speed_level_i = 9'h000;
  logic [8:0] duty_limit_i = 9'h1ff;
  logic [6:0] elec_angle_i = 7'h00;
  logic [2:0] lock_cause_i, phase_oe_o;
  logic [7:0] reg_rdata_o;
  logic vreg_target_sel_o, vreg_hs_on_o, vreg_en_o, serial_en_o, uvlo_o;
  logic [8:0] output_peak_duty_o, duty_u_o, duty_v_o, duty_w_o, m;
  int num_errors = 0;
  int compares = 0;
  int n;

  mds_supervisor #(.LOCK_OFF_CYC(20), .LOCK_ENTER_CYC(5), .LP_ENTER_CYC(8),
    .LP_EXIT_CYC(4)) dut (.mclk_i(mclk_i), .arst_n_i(arst_n_i), .cen_i(cen_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .speed_pin_i(speed_pin_i),
    .speed_level_i(speed_level_i), .temp_over_i(temp_over_i), .temp_cool_i(temp_cool_i),
    .vcc_fall_i(vcc_fall_i), .vcc_rise_i(vcc_rise_i), .oc_i(oc_i), .lock_i(lock_i),
    .lock_cause_i(lock_cause_i), .duty_limit_i(duty_limit_i),
    .elec_angle_i(elec_angle_i), .vreg_low_i(vreg_low_i), .vreg_ok_i(vreg_ok_i),
    .vreg_target_sel_o(vreg_target_sel_o), .vreg_hs_on_o(vreg_hs_on_o),
    .vreg_en_o(vreg_en_o), .serial_en_o(serial_en_o), .uvlo_o(uvlo_o),
    .output_peak_duty_o(output_peak_duty_o), .duty_u_o(duty_u_o), .duty_v_o(duty_v_o),
    .duty_w_o(duty_w_o), .phase_oe_o(phase_oe_o));

  mds_motor_model #(.CAUSE(3'h5)) motor (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .blocked_i(blocked), .phase_oe_i(phase_oe_o), .lock_o(lock_i),
    .lock_cause_o(lock_cause_i));

  // ****************
  // access tasks
  // ****************
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge mclk_i);
  endtask
  // a spare cycle after each strobe keeps back-to-back calls from reassigning it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    cyc(1);
    reg_wr_i = 1'b0;
    cyc(1);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    cyc(1);
    reg_rd_i = 1'b0;
    chk("reg_rdata_o", {1'b0, exp}, {1'b0, reg_rdata_o});
    cyc(1);
  endtask
  task automatic results;
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    forever #50 mclk_i = ~mclk_i;
  end
  initial begin
    #2000000;
    num_errors++;
    results;
  end

  // ****************
  // tests
  // ****************
  initial begin
    cyc(1);
    chk("phase_oe_o", 9'h007, {6'h00, phase_oe_o});
    chk("serial_en_o", 9'h001, {8'h00, serial_en_o});
    cyc(1);
    arst_n_i = 1'b1;
    rd(8'h10, 8'h00);
    rd(8'h1e, 8'h00);
    rd(8'h55, 8'h00);
    wr(8'h10, 8'hff);
    rd(8'h10, 8'h00);
    wr(8'h02, 8'h01);
    chk("vreg_target_sel_o", 9'h001, {8'h00, vreg_target_sel_o});
    wr(8'h02, 8'h00);
    chk("vreg_target_sel_o", 9'h000, {8'h00, vreg_target_sel_o});
    // serial source, nine-bit command, then a lower external ceiling
    wr(8'h00, 8'h40);
    wr(8'h01, 8'h01);
    wr(8'h02, 8'h08);
    cyc(3);
    chk("output_peak_duty_o", 9'h140, output_peak_duty_o);
    duty_limit_i = 9'h0a0;
    cyc(3);
    chk("output_peak_duty_o", 9'h0a0, output_peak_duty_o);
    for (int a = 0; a < 96; a += 16) begin
      elec_angle_i = 7'(a);
      cyc(3);
      m = duty_u_o < duty_v_o ? duty_u_o : duty_v_o;
      m = m < duty_w_o ? m : duty_w_o;
      chk("zero_phase", 9'h000, m);
      chk("driven", 9'h001, {8'h00, |(duty_u_o | duty_v_o | duty_w_o)});
    end
    // protections: set inputs other than the oc_i level are one-cycle pulses, clear inputs are held for two cycles
    temp_over_i = 1'b1;
    cyc(1);
    temp_over_i = 1'b0;
    cyc(2);
    chk("phase_oe_o", 9'h000, {6'h00, phase_oe_o});
    rd(8'h10, 8'h80);
    temp_cool_i = 1'b1;
    cyc(2);
    temp_cool_i = 1'b0;
    chk("phase_oe_o", 9'h007, {6'h00, phase_oe_o});
    rd(8'h10, 8'h00);
    oc_i = 1'b1;
    cyc(3);
    chk("phase_oe_o", 9'h000, {6'h00, phase_oe_o});
    chk("duty_u_o", 9'h000, duty_u_o);
    rd(8'h10, 8'h20);
    oc_i = 1'b0;
    cyc(2);
    chk("phase_oe_o", 9'h007, {6'h00, phase_oe_o});
    vcc_fall_i = 1'b1;
    cyc(1);
    vcc_fall_i = 1'b0;
    cyc(2);
    chk("uvlo_o", 9'h001, {8'h00, uvlo_o});
    vcc_rise_i = 1'b1;
    cyc(2);
    vcc_rise_i = 1'b0;
    chk("uvlo_o", 9'h000, {8'h00, uvlo_o});
    vreg_low_i = 1'b1;
    cyc(1);
    vreg_low_i = 1'b0;
    cyc(2);
    chk("vreg_hs_on_o", 9'h001, {8'h00, vreg_hs_on_o});
    vreg_ok_i = 1'b1;
    cyc(2);
    vreg_ok_i = 1'b0;
    chk("vreg_hs_on_o", 9'h000, {8'h00, vreg_hs_on_o});
    // a low clock enable must hold off the over-temperature flag and drop register writes
    cen_i = 1'b0;
    temp_over_i = 1'b1;
    wr(8'h02, 8'h09);
    temp_over_i = 1'b0;
    cen_i = 1'b1;
    chk("vreg_target_sel_o", 9'h000, {8'h00, vreg_target_sel_o});
    chk("phase_oe_o", 9'h007, {6'h00, phase_oe_o});
    // blocked rotor: off span, retry, relock, then a clean retry
    blocked = 1'b1;
    cyc(3);
    chk("phase_oe_o", 9'h000, {6'h00, phase_oe_o});
    rd(8'h10, 8'h10);
    rd(8'h1e, 8'h05);
    n = 5;
    while (phase_oe_o === 3'h0 && n < 60) begin
      cyc(1);
      n++;
    end
    chk("lock_off_span", 9'h014, 9'(n));
    cyc(3);
    chk("phase_oe_o", 9'h000, {6'h00, phase_oe_o});
    blocked = 1'b0;
    cyc(40);
    rd(8'h10, 8'h00);
    chk("phase_oe_o", 9'h007, {6'h00, phase_oe_o});
    // serial command zero enters standby, nonzero leaves it
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    cyc(10);
    rd(8'h10, 8'h40);
    wr(8'h00, 8'h01);
    cyc(6);
    rd(8'h10, 8'h00);
    // pin source: low pin enters standby, which keeps registers and serial port
    wr(8'h02, 8'h00);
    speed_pin_i = 1'b0;
    cyc(10);
    rd(8'h10, 8'h40);
    chk("phase_oe_o", 9'h000, {6'h00, phase_oe_o});
    chk("serial_en_o", 9'h001, {8'h00, serial_en_o});
    chk("vreg_en_o", 9'h001, {8'h00, vreg_en_o});
    rd(8'h00, 8'h01);
    wr(8'h02, 8'h02);
    cyc(2);
    rd(8'h10, 8'h40);
    speed_pin_i = 1'b1;
    cyc(6);
    rd(8'h10, 8'h00);
    speed_pin_i = 1'b0;
    cyc(12);
    rd(8'h10, 8'h00);
    // analog source: level sets the command, a low level enters standby, a higher one leaves
    speed_level_i = 9'h080;
    wr(8'h02, 8'h04);
    cyc(2);
    chk("output_peak_duty_o", 9'h080, output_peak_duty_o);
    speed_level_i = 9'h008;
    cyc(10);
    rd(8'h10, 8'h40);
    speed_level_i = 9'h030;
    cyc(6);
    rd(8'h10, 8'h00);
    results;
  end
endmodule
